// *** sim/hcms_actuator_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// actuator model: a heater and a chiller that run while their mv is set
module hcms_actuator_model
    import hcms_pkg::*;
(
    // clock
    input wire logic clk_i,
    // drive from the shaper
    input wire logic [15:0] heat_mv_i,
    input wire logic [15:0] cool_mv_i,
    // actuator state
    output logic heat_on_o,
    output logic cool_on_o
);
    // the actuators latch their drive each cycle, a real load reacts late
    always_ff @(posedge clk_i) begin
        heat_on_o <= (heat_mv_i != 16'h0000);
        cool_on_o <= (cool_mv_i != 16'h0000);
    end
endmodule : hcms_actuator_model
`default_nettype wire

// *** sim/heat_cool_mv_output_shaper_test.sv ***
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// bench of the heat/cool output shaper
module heat_cool_mv_output_shaper_test
    import hcms_pkg::*;
();
    // =================================================================
    // stimulus and observed signals
    localparam int TICKS = 20; // short rate step so the ramp fits the run
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic signed [15:0] mv_calc_i = 16'sh0000;
    logic signed [15:0] pv_i = 16'sh0000;
    logic signed [15:0] sp_i = 16'sh0000; // set point stays at zero
    hcms_op_type op_i = '0;
    wire logic [15:0] rdata_o;
    wire logic [15:0] heat_mv_o;
    wire logic [15:0] cool_mv_o;
    wire hcms_pid_type pid_o;
    wire logic heat_on;
    wire logic cool_on;
    logic [15:0] v; // read-back scratch
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    always #20 clk_i = ~clk_i;
    // =================================================================
    // design and far side
    hcms_shaper #(.TICK_COUNT(TICKS)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .mv_calc_i(mv_calc_i), .pv_i(pv_i), .sp_i(sp_i), .op_i(op_i),
        .heat_mv_o(heat_mv_o), .cool_mv_o(cool_mv_o), .pid_o(pid_o));
    hcms_actuator_model load (.clk_i(clk_i), .heat_mv_i(heat_mv_o), .cool_mv_i(cool_mv_o),
        .heat_on_o(heat_on), .cool_on_o(cool_on));
    // =================================================================
    // shared tasks
    task automatic close_out;
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask : rd
    // set mv and deviation, let the registered outputs settle, judge them
    task automatic apply(input logic [15:0] mv, input logic [15:0] pv,
                         input logic [15:0] eh, input logic [15:0] ec);
        @(posedge clk_i);
        mv_calc_i <= mv;
        pv_i <= pv;
        repeat (3) @(posedge clk_i);
        #1;
        chk("heat_mv", eh, heat_mv_o);
        chk("cool_mv", ec, cool_mv_o);
        chk("heat_on", {15'h0, eh != 16'h0}, {15'h0, heat_on});
        chk("cool_on", {15'h0, ec != 16'h0}, {15'h0, cool_on});
    endtask : apply
    // =================================================================
    // scenarios
    task automatic t_reset;
        for (int i = 0; i < REG_COUNT; i++) begin
            rd(i[3:0], v);
            chk("reset reg", REG_RST[i*16 +: 16], v);
        end
        rd(4'he, v);
        chk("unmapped", 16'h0000, v);
        wr(ADDR_STATUS, 16'hffff); // read-only place, must be ignored
        rd(ADDR_STATUS, v);
        chk("method", 16'h0000, v & 16'h00c0);
        chk("prop_band", 16'h0050, pid_o.prop_band);
        chk("integ_time", REG_RST[16*ADDR_INTEG +: 16], pid_o.integ_time);
        chk("deriv_time", REG_RST[16*ADDR_DERIV +: 16], pid_o.deriv_time);
        chk("cool_band", REG_RST[16*ADDR_PROP +: 16], pid_o.cool_band);
        @(posedge clk_i);
        #1;
        chk("rdata idle", 16'h0000, rdata_o);
    endtask : t_reset
    task automatic t_heat_pid;
        apply(16'd500, 16'h0, 16'd500, 16'h0);
        apply(16'hfed4, 16'h0, 16'h0, 16'h0);
        wr(ADDR_UPPER, 16'd600);
        apply(16'd800, 16'h0, 16'd600, 16'h0);
        rd(ADDR_MVMON, v);
        chk("mv monitor", 16'd600, v);
    endtask : t_heat_pid
    task automatic t_heatcool;
        wr(ADDR_CTRL, 16'h0009);
        wr(ADDR_LOWER, 16'hfed4); // -300
        apply(16'hfe0c, 16'h0, 16'h0, 16'd300);
        apply(16'd700, 16'h0, 16'd600, 16'h0);
        rd(ADDR_STATUS, v);
        chk("method", 16'h0080, v & 16'h00c0);
        wr(ADDR_BAND, 16'd200); // half width 100 each side
        apply(16'd400, 16'd50, 16'h0, 16'h0);
        apply(16'd400, 16'd150, 16'd400, 16'h0);
        wr(ADDR_COEF, 16'd200);
        wr(ADDR_PROP, 16'h0030);
        repeat (2) @(posedge clk_i);
        #1;
        chk("prop_band", 16'h0030, pid_o.prop_band);
        chk("cool_band", 16'h0060, pid_o.cool_band);
    endtask : t_heatcool
    task automatic t_stop;
        op_i.stopped <= 1'b1;
        wr(ADDR_STOP, 16'hff06); // -250
        apply(16'd500, 16'h0, 16'h0, 16'd250);
        wr(ADDR_STOP, 16'd900); // above the upper limit, not clamped
        apply(16'd500, 16'h0, 16'd900, 16'h0);
        wr(ADDR_STOP, 16'h0000);
        apply(16'd500, 16'h0, 16'h0, 16'h0);
        op_i.stopped <= 1'b0;
    endtask : t_stop
    task automatic t_onoff;
        wr(ADDR_CTRL, 16'h0029); // heat/cool, on/off, band still 200
        apply(16'h0, 16'hff6a, 16'd1000, 16'h0);
        apply(16'h0, 16'h0, 16'h0, 16'h0);
        apply(16'h0, 16'd150, 16'h0, 16'd1000);
        apply(16'h0, 16'd104, 16'h0, 16'd1000);
        apply(16'h0, 16'd90, 16'h0, 16'h0);
        wr(ADDR_CTRL, 16'h0021); // heating on/off, upper limit 600 bypassed
        apply(16'h0, 16'hffec, 16'd1000, 16'h0);
        apply(16'h0, 16'hfffc, 16'd1000, 16'h0);
        apply(16'h0, 16'd5, 16'h0, 16'h0);
        apply(16'h0, 16'hfffc, 16'h0, 16'h0);
        wr(ADDR_CTRL, 16'h0031); // cooling on/off
        wr(ADDR_CHYS, 16'd2); // a cool margin that must not be used
        apply(16'h0, 16'd5, 16'h0, 16'h0);
        apply(16'h0, 16'd20, 16'd1000, 16'h0);
        apply(16'h0, 16'hffff, 16'h0, 16'h0);
    endtask : t_onoff
    task automatic t_rate;
        wr(ADDR_CTRL, 16'h0001);
        wr(ADDR_UPPER, 16'd1000);
        apply(16'h0, 16'h0, 16'h0, 16'h0);
        wr(ADDR_RATE, 16'd100);
        mv_calc_i <= 16'sd350;
        for (int i = 0; i < TICKS + 5 && heat_mv_o === 16'h0; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk("ramp", 16'd100, heat_mv_o);
        for (int k = 2; k <= 4; k++) begin
            repeat (TICKS) @(posedge clk_i);
            #1;
            chk("ramp", (k == 4) ? 16'd350 : 16'(k * 100), heat_mv_o);
        end
        wr(ADDR_UPPER, 16'd250);
        apply(16'd350, 16'h0, 16'd250, 16'h0);
        op_i.autotune <= 1'b1;
        apply(16'h0, 16'h0, 16'h0, 16'h0);
    endtask : t_rate
    // manual and error bypass the limiters, an unassigned method stays quiet
    task automatic t_bypass;
        op_i.autotune <= 1'b0;
        op_i.manual <= 1'b1; // upper limit is still 250
        apply(16'd350, 16'h0, 16'd350, 16'h0);
        op_i.manual <= 1'b0;
        op_i.error <= 1'b1;
        apply(16'd400, 16'h0, 16'd400, 16'h0);
        op_i.error <= 1'b0;
        chk("cool_band", 16'h0030, pid_o.cool_band);
        wr(ADDR_CTRL, 16'h0000); // no output assigned
        apply(16'd500, 16'h0, 16'h0, 16'h0);
    endtask : t_bypass
    // =================================================================
    // run control: bounded run, then the verdict
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_heat_pid();
        t_heatcool();
        t_stop();
        t_onoff();
        t_rate();
        t_bypass();
        close_out();
    end
endmodule : heat_cool_mv_output_shaper_test
`default_nettype wire

// *** verilog/hcms_pkg.sv ***
`default_nettype none
// =====================================================================
// shared constants and carriers of the heat/cool output shaper
package hcms_pkg;
    // =================================================================
    // timebase
    localparam int unsigned CLK_HZ = 25_000_000; // clk_i rate
    localparam int unsigned TICK_MS = 1000; // rate limiter step period, ms
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // =================================================================
    // register index map (16-bit data, one register per index)
    localparam int REG_COUNT = 12; // writable registers 0..11
    localparam logic [3:0] ADDR_CTRL = 4'h0; // assignments, action, type
    localparam logic [3:0] ADDR_BAND = 4'h1; // band_width_setting, 0.01 %FS
    localparam logic [3:0] ADDR_COEF = 4'h2; // cooling coefficient, 0.01
    localparam logic [3:0] ADDR_STOP = 4'h3; // stop mv, 0.1 %
    localparam logic [3:0] ADDR_HHYS = 4'h4; // heat_switch_margin
    localparam logic [3:0] ADDR_CHYS = 4'h5; // cool switch margin
    localparam logic [3:0] ADDR_UPPER = 4'h6; // mv upper limit
    localparam logic [3:0] ADDR_LOWER = 4'h7; // mv lower limit
    localparam logic [3:0] ADDR_RATE = 4'h8; // max mv change per second
    localparam logic [3:0] ADDR_PROP = 4'h9; // proportional band
    localparam logic [3:0] ADDR_INTEG = 4'ha; // integral time
    localparam logic [3:0] ADDR_DERIV = 4'hb; // derivative time
    localparam logic [3:0] ADDR_STATUS = 4'hc; // read-only state
    localparam logic [3:0] ADDR_MVMON = 4'hd; // read-only shaped mv
    // =================================================================
    // control register fields
    localparam int CTRL_OUT1_LSB = 0; // output one assignment, 2 bits
    localparam int CTRL_OUT2_LSB = 2; // output two assignment, 2 bits
    localparam int CTRL_DIR_BIT = 4; // action_direction_select: 1 direct
    localparam int CTRL_ONOFF_BIT = 5; // control type: 1 on/off
    localparam logic [1:0] ASSIGN_HEAT = 2'h1;
    localparam logic [1:0] ASSIGN_COOL = 2'h2;
    // =================================================================
    // reset values, index 11 leftmost
    localparam logic [REG_COUNT*16-1:0] REG_RST = {
        16'h0028, 16'h00e9, 16'h0050, 16'h0000, 16'hfc18, 16'h03e8,
        16'h0008, 16'h0008, 16'h0000, 16'h0064, 16'h0000, 16'h0001};
    localparam logic signed [15:0] MV_FULL = 16'sh03e8; // 100.0 %
    localparam logic [31:0] COEF_SCALE = 32'h0000_0064; // coefficient 1.00
    // =================================================================
    // types
    typedef enum logic [1:0] {
        METH_HEAT = 2'b00,
        METH_COOL = 2'b01,
        METH_HEATCOOL = 2'b10,
        METH_NONE = 2'b11
    } hcms_method_type;
    typedef struct packed {
        logic stopped;
        logic manual;
        logic autotune;
        logic error;
    } hcms_op_type;
    typedef struct packed {
        logic [15:0] prop_band;
        logic [15:0] integ_time;
        logic [15:0] deriv_time;
        logic [15:0] cool_band;
    } hcms_pid_type;
endpackage : hcms_pkg
`default_nettype wire

// *** verilog/hcms_shaper.sv ***
`timescale 1ns/1ps
`default_nettype none
module hcms_shaper
    import hcms_pkg::*;
#(
    parameter int unsigned TICK_COUNT = TICK_CYCLES // shorten in simulation
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // process inputs
    input wire logic signed [15:0] mv_calc_i,
    input wire logic signed [15:0] pv_i,
    input wire logic signed [15:0] sp_i,
    input wire hcms_op_type op_i,
    // outputs to actuators and pid block
    output logic [15:0] heat_mv_o,
    output logic [15:0] cool_mv_o,
    output hcms_pid_type pid_o
);
    // =================================================================
    // register file
    logic [15:0] cfg [REG_COUNT]; // writable settings
    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_reg
            // each register loads on its own index
            always_ff @(posedge clk_i) begin
                if (sys_rst_i) begin
                    cfg[g] <= REG_RST[g*16 +: 16];
                end else if (wr_i && addr_i == 4'(g)) begin
                    cfg[g] <= wdata_i;
                end
            end
        end
    endgenerate
    wire logic [15:0] ctrl = cfg[ADDR_CTRL];
    wire logic signed [15:0] band = cfg[ADDR_BAND];
    wire logic signed [15:0] stop_mv = cfg[ADDR_STOP];
    wire logic signed [15:0] mv_upper = cfg[ADDR_UPPER];
    wire logic signed [15:0] mv_lower = cfg[ADDR_LOWER];
    wire logic [15:0] rate = cfg[ADDR_RATE];
    wire logic onoff = ctrl[CTRL_ONOFF_BIT];
    // =================================================================
    // control method decode
    wire logic [1:0] out1 = ctrl[CTRL_OUT1_LSB +: 2];
    wire logic [1:0] out2 = ctrl[CTRL_OUT2_LSB +: 2];
    wire logic dir = ctrl[CTRL_DIR_BIT];
    wire logic heat_one = (out1 == ASSIGN_HEAT);
    wire logic cool_two = (out2 == ASSIGN_COOL);
    // unsupported combinations drive nothing rather than guess a side
    wire hcms_method_type method = (heat_one && cool_two && !dir) ? METH_HEATCOOL :
        (heat_one && !cool_two) ? (dir ? METH_COOL : METH_HEAT) : METH_NONE;
    wire logic hc = (method == METH_HEATCOOL);
    // =================================================================
    // deviation and band arithmetic, 18 bits so no sum can wrap
    wire logic signed [17:0] dev = {{2{pv_i[15]}}, pv_i} - {{2{sp_i[15]}}, sp_i};
    wire logic signed [17:0] half = {{3{band[15]}}, band[15:1]}; // half width
    wire logic signed [17:0] hh = {2'b00, cfg[ADDR_HHYS]};
    wire logic signed [17:0] ch = {2'b00, cfg[ADDR_CHYS]};
    wire logic signed [17:0] adev = dev[17] ? -dev : dev;
    // a negative width leaves no zero zone, only the overlap of the switch points;
    // a zero width must not blank the output exactly at the set point either
    wire logic in_band = hc && !band[15] && (half != 18'sh0) && (adev <= half);
    // =================================================================
    // on/off switching with hysteresis
    logic heat_on; // heat output switched on
    logic cool_on; // cool output switched on
    logic next_heat_on;
    logic next_cool_on;
    wire logic onoff_run = onoff && !op_i.stopped;
    always_comb begin
        next_heat_on = heat_on;
        next_cool_on = 1'b0;
        case (method)
            METH_HEAT: begin
                // reverse action: on below set point minus margin
                if (dev < -hh) begin
                    next_heat_on = 1'b1;
                end else if (dev > 18'sh0) begin
                    next_heat_on = 1'b0;
                end
            end
            METH_COOL: begin
                // direct action on the heat output, heat margin only
                if (dev > hh) begin
                    next_heat_on = 1'b1;
                end else if (dev < 18'sh0) begin
                    next_heat_on = 1'b0;
                end
            end
            METH_HEATCOOL: begin
                // switch points at the band edges give three positions
                if (dev < -half - hh) begin
                    next_heat_on = 1'b1;
                end else if (dev > -half) begin
                    next_heat_on = 1'b0;
                end
                next_cool_on = cool_on;
                if (dev > half + ch) begin
                    next_cool_on = 1'b1;
                end else if (dev < half) begin
                    next_cool_on = 1'b0;
                end
            end
            default: begin
                next_heat_on = 1'b0;
            end
        endcase
        if (!onoff_run) begin
            next_heat_on = 1'b0;
            next_cool_on = 1'b0;
        end
    end
    // on/off state registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            heat_on <= 1'b0;
            cool_on <= 1'b0;
        end else begin
            heat_on <= next_heat_on;
            cool_on <= next_cool_on;
        end
    end
    // =================================================================
    // one second tick for the rate limiter
    logic [24:0] tick_cnt; // cycles into the current second
    wire logic tick = (tick_cnt == 25'(TICK_COUNT - 1));
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || tick) begin
            tick_cnt <= 25'h0;
        end else begin
            tick_cnt <= tick_cnt + 25'h1;
        end
    end
    // =================================================================
    // rate limiter, then clamp
    wire logic bypass_lim = onoff || op_i.manual || op_i.stopped || op_i.error;
    wire logic bypass_rate = bypass_lim || op_i.autotune;
    logic signed [15:0] mv_rl; // rate limited mv
    wire logic signed [17:0] rate18 = {2'b00, rate};
    wire logic signed [17:0] diff = {{2{mv_calc_i[15]}}, mv_calc_i} - {{2{mv_rl[15]}}, mv_rl};
    wire logic step_up = diff > rate18;
    wire logic step_dn = diff < -rate18;
    wire logic signed [15:0] mv_step = step_up ? mv_rl + signed'(rate) :
        step_dn ? mv_rl - signed'(rate) : mv_calc_i;
    wire logic rate_on = !bypass_rate && (rate != 16'h0);
    // while bypassed the limiter tracks, so re-entry starts from the live value
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            mv_rl <= 16'sh0;
        end else if (!rate_on) begin
            mv_rl <= mv_calc_i;
        end else if (tick) begin
            mv_rl <= mv_step;
        end
    end
    wire logic clamp_hi = !bypass_lim && (mv_rl > mv_upper);
    wire logic clamp_lo = !bypass_lim && (mv_rl < mv_lower);
    wire logic signed [15:0] mv_lim = bypass_lim ? mv_calc_i : clamp_hi ? mv_upper :
        clamp_lo ? mv_lower : mv_rl;
    // =================================================================
    // final mv and output split
    wire logic signed [15:0] mv_onoff = heat_on ? MV_FULL : cool_on ? -MV_FULL : 16'sh0;
    wire logic signed [15:0] mv_fin = op_i.stopped ? stop_mv : onoff ? mv_onoff :
        in_band ? 16'sh0 : mv_lim;
    wire logic [15:0] next_heat = (method == METH_NONE || mv_fin[15]) ? 16'h0 :
        16'(mv_fin);
    wire logic [15:0] next_cool = (hc && mv_fin[15]) ? 16'(-mv_fin) : 16'h0;
    wire logic [31:0] cool_prod = cfg[ADDR_PROP] * cfg[ADDR_COEF];
    wire logic [31:0] cool_p = cool_prod / COEF_SCALE;
    logic signed [15:0] mv_mon; // last shaped mv for software
    // output registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            heat_mv_o <= 16'h0;
            cool_mv_o <= 16'h0;
            mv_mon <= 16'sh0;
            pid_o <= '0;
        end else begin
            heat_mv_o <= next_heat;
            cool_mv_o <= next_cool;
            mv_mon <= mv_fin;
            pid_o.prop_band <= cfg[ADDR_PROP];
            pid_o.integ_time <= cfg[ADDR_INTEG];
            pid_o.deriv_time <= cfg[ADDR_DERIV];
            // in heating-only control the cooling band is unused but kept equal to P
            pid_o.cool_band <= hc ? cool_p[15:0] : cfg[ADDR_PROP];
        end
    end
    // =================================================================
    // read port
    wire logic [15:0] status = {8'h00, method, heat_on, cool_on, in_band, rate_on,
        clamp_hi, clamp_lo};
    wire logic [15:0] rd_mux = (addr_i < 4'(REG_COUNT)) ? cfg[addr_i] :
        (addr_i == ADDR_STATUS) ? status : (addr_i == ADDR_MVMON) ? 16'(mv_mon) : 16'h0;
    // data stand only in the cycle after the strobe
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !rd_i) begin
            rdata_o <= 16'h0;
        end else begin
            rdata_o <= rd_mux;
        end
    end
    // =================================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // a write of p followed by two quiet cycles
    sequence s_write_prop;
        wr_i && addr_i == ADDR_PROP;
    endsequence
    sequence s_settle;
        !wr_i [*2];
    endsequence
    // the on/off state flips first, the output follows one cycle later
    sequence s_heat_full;
        heat_on ##1 heat_mv_o == 16'(MV_FULL);
    endsequence
    // reset settings select heating with pid
    a_default_method: assert property (
        $past(sys_rst_i) |-> method == METH_HEAT && !onoff)
        else $error("reset settings not heating pid");
    // direct action on a lone heat output is cooling
    a_cool_direct: assert property (
        heat_one && !cool_two && dir |-> method == METH_COOL)
        else $error("direct standard not cooling");
    // no assigned output, nothing driven
    a_none_quiet: assert property (
        method == METH_NONE |=> heat_mv_o == 16'h0 && cool_mv_o == 16'h0)
        else $error("unassigned method drove an output");
    // only heating and cooling control may drive the cool output
    a_cool_idle: assert property (
        !hc |=> cool_mv_o == 16'h0)
        else $error("cool output driven outside heat/cool");
    // a non-negative stop value goes straight to the heat side in heating control
    a_stop_heat: assert property (
        op_i.stopped && method == METH_HEAT && !stop_mv[15]
        |=> heat_mv_o == 16'($past(stop_mv)) && cool_mv_o == 16'h0)
        else $error("stop mv not on heat output");
    // zero stop value drives neither side
    a_stop_zero: assert property (
        op_i.stopped && stop_mv == 16'sh0 |=> heat_mv_o == 16'h0 && cool_mv_o == 16'h0)
        else $error("zero stop mv drove an output");
    // pid mode inside the dead band is quiet
    a_band_zero: assert property (
        !op_i.stopped && !onoff && in_band |=> heat_mv_o == 16'h0 && cool_mv_o == 16'h0)
        else $error("output inside dead band");
    // heating on/off switches on below the margin
    a_heat_onoff: assert property (
        onoff_run && method == METH_HEAT && dev < -hh |=> s_heat_full)
        else $error("heat on/off did not switch on");
    // on/off output is full scale and skips the limiters
    a_onoff_full: assert property (
        onoff_run && heat_on |=> mv_mon == MV_FULL)
        else $error("on/off heat not at full scale");
    // heat and cool never both on with a dead band
    a_three_pos: assert property (
        hc && !band[15] && $stable(band) && !$past(heat_on && cool_on)
        |-> !(heat_on && cool_on))
        else $error("heat and cool both on");
    // rate limited mv above the upper limit is held there
    a_clamp_upper: assert property (
        !bypass_lim && !in_band && mv_rl > mv_upper |=> mv_mon == $past(mv_upper))
        else $error("mv not held at upper limit");
    // rate limited mv below the lower limit is held there
    a_clamp_lower: assert property (
        !bypass_lim && !in_band && !clamp_hi && mv_rl < mv_lower
        |=> mv_mon == $past(mv_lower))
        else $error("mv not held at lower limit");
    // one rate step per tick, never more
    a_rate_step: assert property (
        rate_on && tick && step_up |=> mv_rl == $past(mv_rl) + signed'($past(rate)))
        else $error("rate step wrong");
    // between ticks the limited value holds
    a_rate_hold: assert property (
        rate_on && !tick |=> $stable(mv_rl))
        else $error("rate limited mv moved off tick");
    // manual operation passes the computed mv unlimited
    a_manual_pass: assert property (
        op_i.manual && !op_i.stopped && !onoff && !in_band |=> mv_mon == $past(mv_calc_i))
        else $error("limiter not bypassed in manual");
    // an error condition passes the computed mv unlimited
    a_error_pass: assert property (
        op_i.error && !op_i.stopped && !onoff && !in_band |=> mv_mon == $past(mv_calc_i))
        else $error("limiter not bypassed on error");
    // a written p reaches the pid block two cycles on
    a_pid_write: assert property (
        s_write_prop ##1 s_settle |-> pid_o.prop_band == $past(wdata_i, 2))
        else $error("written p not passed on");
endmodule : hcms_shaper
`default_nettype wire
